// ==== rtl/ilp_pkg.sv ====
// Constants shared by the interrupt level, priority and mask controller.
package ilp_pkg;

  // ----------------------------------------------------------------
  // Sources and register indices (byte address is four times index)
  // ----------------------------------------------------------------
  localparam int NSRC = 16;
  localparam int NCTL = 15;
  localparam int EXT_LAST = 7;
  localparam int WD_ID = 8;
  localparam int TMR1_ID = 9;
  localparam int I2C_ID = 11;
  localparam int ADDR_W = 10;
  localparam logic [7:0] CTL_IDX_BASE = 8'h14;
  localparam logic [7:0] MASK_IDX = 8'h36;
  localparam logic [7:0] PEND_IDX = 8'h3A;
  localparam logic [7:0] WDVEC_IDX = 8'h42;
  localparam logic [7:0] STAT_IDX = 8'h50;
  localparam logic [7:0] CLR_IDX = 8'h51;
  localparam logic [7:0] EN_IDX = 8'h52;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int AUTOVEC_BIT = 7;
  localparam int LVL_HI = 4;
  localparam int LVL_LO = 2;
  localparam int PRI_HI = 1;
  localparam int PRI_LO = 0;

  // ----------------------------------------------------------------
  // Reset values and writable bits per source (entry 0 unused)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RST [NSRC] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h18, 8'h1C, 8'h1C, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTL_WMASK [NSRC] = '{8'h00, 8'h83, 8'h83, 8'h83, 8'h83, 8'h83,
    8'h83, 8'h83, 8'h03, 8'h1F, 8'h1F, 8'h1F, 8'h9F, 8'h9F, 8'h9F, 8'h9F};
  localparam logic [15:0] MASK_RST = 16'h3FFE;
  localparam logic [15:0] MASK_USED = 16'hFFFE;
  localparam logic [7:0] WDVEC_RST = 8'h0F;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;

endpackage : ilp_pkg

// ==== rtl/ilp_arb_if.sv ====
// Carrier between the register side and the priority resolver.
interface ilp_arb_if;
  logic [15:0] req;
  logic [2:0] lvl [16];
  logic [1:0] pri [16];
  logic [2:0] top_lvl;
  logic [3:0] win_id;
  logic win_vld;
  modport arb (input req, input lvl, input pri, output top_lvl, output win_id, output win_vld);
  modport ctl (output req, output lvl, output pri, input top_lvl, input win_id, input win_vld);
endinterface : ilp_arb_if

// ==== rtl/ilp_arbiter.sv ====
// Priority resolver: picks the highest level, then highest priority.
module ilp_arbiter (
  ilp_arb_if.arb bus
);

  // ----------------------------------------------------------------
  // Ranking keys
  // ----------------------------------------------------------------
  logic [4:0] key [16];

  // Level above priority in one key; level zero never competes
  for (genvar g = 0; g < 16; g++) begin : g_key
    assign key[g] = (bus.req[g] && bus.lvl[g] != 3'h0) ? {bus.lvl[g], bus.pri[g]} : 5'h00;
  end

  // Strict compare: on a duplicate pair the lower index wins
  always_comb begin
    logic [4:0] best;
    logic [3:0] id;
    best = 5'h00;
    id = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (key[i] > best) begin
        best = key[i];
        id = 4'(i);
      end
    end
    bus.top_lvl = best[4:2];
    bus.win_id = id;
    bus.win_vld = (best != 5'h00);
  end

endmodule // ilp_arbiter

// ==== rtl/ilp_ctrl.sv ====
// Interrupt level, priority and mask controller with APB register access.
//
// Added by the designer: the register addresses and register access over APB.
module ilp_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ilp_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [6:0] i_ext_irq,
  input wire logic [7:0] i_per_irq,
  input wire logic i_iack_req,
  input wire logic [2:0] i_iack_lvl,
  output logic [2:0] o_ipl,
  output logic o_iack_ack,
  output logic o_iack_autovec,
  output logic [7:0] o_iack_vector,
  output logic [3:0] o_iack_src,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ilp_arb_if arb_bus ();
  logic [6:0] ext_s1_r;
  logic [6:0] ext_s2_r;
  logic [15:0] raw;
  logic [15:0] pend_r;
  logic [15:0] mask_r;
  logic [7:0] ctl_r [16];
  logic [7:0] ctl_rd [16];
  logic [7:0] wdvec_r;
  logic [15:0] stat_r;
  logic [15:0] en_r;
  logic [15:0] ev;
  logic [7:0] idx;
  logic [7:0] ctl_off;
  logic ctl_hit;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;
  logic [2:0] ipl_r;
  logic ack_r;
  logic autovec_r;
  logic [7:0] vec_r;
  logic [3:0] src_r;
  logic [2:0] ack_lvl_r;
  logic [7:0] win_ctl;
  logic win_ok;

  // ----------------------------------------------------------------
  // Pin synchronisers and raw requests
  // ----------------------------------------------------------------
  // Externals come from pins; internal peripherals share our clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_s1_r <= 7'h00;
      ext_s2_r <= 7'h00;
    end else begin
      ext_s1_r <= i_ext_irq;
      ext_s2_r <= ext_s1_r;
    end
  end

  // Externals are single requests each; encoded level inputs are not modelled
  assign raw = {i_per_irq, ext_s2_r, 1'b0};

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  // Set the cycle after a request, drop with it; mask plays no part
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= 16'h0000;
    end else begin
      pend_r <= raw;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx = i_paddr[ilp_pkg::ADDR_W-1:2];
  assign ctl_off = idx - ilp_pkg::CTL_IDX_BASE;
  assign ctl_hit = (idx >= ilp_pkg::CTL_IDX_BASE) && (ctl_off < 8'(ilp_pkg::NCTL));
  assign mapped = ctl_hit || idx == ilp_pkg::MASK_IDX || idx == ilp_pkg::PEND_IDX ||
                  idx == ilp_pkg::WDVEC_IDX || idx == ilp_pkg::STAT_IDX ||
                  idx == ilp_pkg::CLR_IDX || idx == ilp_pkg::EN_IDX;
  assign wr_en = i_psel && i_penable && i_pwrite && mapped;
  assign rd_setup = i_psel && !i_penable;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata = prdata_r;

  // ----------------------------------------------------------------
  // Per-source control registers
  // ----------------------------------------------------------------
  // Only writable bits are stored; fixed bits come back from reset pattern
  for (genvar g = 0; g < 16; g++) begin : g_ctl
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        ctl_r[g] <= ilp_pkg::CTL_RST[g] & ilp_pkg::CTL_WMASK[g];
      end else if (wr_en && ctl_hit && ctl_off == 8'(g - 1)) begin
        ctl_r[g] <= i_pwdata[7:0] & ilp_pkg::CTL_WMASK[g];
      end
    end
    // Reserved levels and autovector bits read their fixed values
    assign ctl_rd[g] = (ctl_r[g] & ilp_pkg::CTL_WMASK[g]) |
                       (ilp_pkg::CTL_RST[g] & ~ilp_pkg::CTL_WMASK[g]);
    assign arb_bus.lvl[g] = ctl_rd[g][ilp_pkg::LVL_HI:ilp_pkg::LVL_LO];
    assign arb_bus.pri[g] = ctl_rd[g][ilp_pkg::PRI_HI:ilp_pkg::PRI_LO];
  end

  // ----------------------------------------------------------------
  // Mask and watchdog vector registers
  // ----------------------------------------------------------------
  // Mask resets blocking sources 1 to 13 but not 14 and 15; no ordering against control writes is enforced
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= ilp_pkg::MASK_RST;
    end else if (wr_en && idx == ilp_pkg::MASK_IDX) begin
      mask_r <= i_pwdata[15:0] & ilp_pkg::MASK_USED;
    end
  end

  // Vector handed back when the watchdog is acknowledged
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wdvec_r <= ilp_pkg::WDVEC_RST;
    end else if (wr_en && idx == ilp_pkg::WDVEC_IDX) begin
      wdvec_r <= i_pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Event status, clear and enable
  // ----------------------------------------------------------------
  // New pending edges are events; a set in the clear cycle survives
  assign ev = raw & ~pend_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_r <= 16'h0000;
    end else if (wr_en && idx == ilp_pkg::CLR_IDX) begin
      stat_r <= (stat_r & ~i_pwdata[15:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_r <= 16'h0000;
    end else if (wr_en && idx == ilp_pkg::EN_IDX) begin
      en_r <= i_pwdata[15:0] & ilp_pkg::MASK_USED;
    end
  end

  assign o_irq = |(stat_r & en_r);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured in setup so the access phase can finish without wait
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (ctl_hit) begin
      rd_nxt[7:0] = ctl_rd[ctl_off[3:0] + 4'h1];
    end else if (idx == ilp_pkg::MASK_IDX) begin
      rd_nxt[15:0] = mask_r;
    end else if (idx == ilp_pkg::PEND_IDX) begin
      rd_nxt[15:0] = pend_r;
    end else if (idx == ilp_pkg::WDVEC_IDX) begin
      rd_nxt[7:0] = wdvec_r;
    end else if (idx == ilp_pkg::STAT_IDX) begin
      rd_nxt[15:0] = stat_r;
    end else if (idx == ilp_pkg::EN_IDX) begin
      rd_nxt[15:0] = en_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Priority resolution toward the core
  // ----------------------------------------------------------------
  assign arb_bus.req = pend_r & ~mask_r;

  ilp_arbiter u_arb (
    .bus (arb_bus.arb)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ipl_r <= 3'h0;
    end else begin
      ipl_r <= arb_bus.top_lvl;
    end
  end

  assign o_ipl = ipl_r;

  // ----------------------------------------------------------------
  // Interrupt acknowledge
  // ----------------------------------------------------------------
  // A level with no winner gets the level-zero autovector as spurious
  assign win_ctl = ctl_rd[arb_bus.win_id];
  assign win_ok = arb_bus.win_vld && arb_bus.top_lvl == i_iack_lvl;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      autovec_r <= 1'b0;
      vec_r <= 8'h00;
      src_r <= 4'h0;
      ack_lvl_r <= 3'h0;
    end else begin
      ack_r <= i_iack_req;
      if (i_iack_req && !win_ok) begin
        autovec_r <= 1'b1;
        vec_r <= ilp_pkg::AUTOVEC_BASE;
        src_r <= 4'h0;
        ack_lvl_r <= 3'h0;
      end else if (i_iack_req) begin
        src_r <= arb_bus.win_id;
        ack_lvl_r <= arb_bus.top_lvl;
        autovec_r <= win_ctl[ilp_pkg::AUTOVEC_BIT];
        if (arb_bus.win_id == 4'(ilp_pkg::WD_ID)) begin
          vec_r <= wdvec_r;
        end else if (win_ctl[ilp_pkg::AUTOVEC_BIT]) begin
          vec_r <= ilp_pkg::AUTOVEC_BASE + {5'h00, arb_bus.top_lvl};
        end else begin
          vec_r <= 8'h00;
        end
      end
    end
  end

  assign o_iack_ack = ack_r;
  assign o_iack_autovec = autovec_r;
  assign o_iack_vector = vec_r;
  assign o_iack_src = src_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  autovec_num_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_iack_ack && o_iack_autovec |-> o_iack_vector == ilp_pkg::AUTOVEC_BASE + {5'h00, ack_lvl_r})
    else $error("autovector number is not level plus 24");

  src_vector_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_iack_ack && !o_iack_autovec && o_iack_src != 4'(ilp_pkg::WD_ID) |-> o_iack_vector == 8'h00)
    else $error("block drove a vector the source should supply");

  wd_vector_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_iack_ack && o_iack_src == 4'(ilp_pkg::WD_ID) |-> !o_iack_autovec && o_iack_vector == wdvec_r)
    else $error("watchdog acknowledge did not return its vector");

  fixed_autovec_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_iack_ack && o_iack_src >= 4'(ilp_pkg::TMR1_ID) && o_iack_src <= 4'(ilp_pkg::I2C_ID)
    |-> o_iack_autovec)
    else $error("timer or i2c acknowledge without autovector");

  ack_timing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_iack_req |=> o_iack_ack ##1 !$past(i_iack_req) || o_iack_ack)
    else $error("acknowledge answer not one cycle after request");

  masked_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pend_r & ~mask_r) == 16'h0000 |=> o_ipl == 3'h0)
    else $error("core request raised with every pending source masked");

  pend_masked_a: assert property (@(posedge i_clk) disable iff (i_rst)
    raw[ilp_pkg::WD_ID] && mask_r[ilp_pkg::WD_ID] |=> pend_r[ilp_pkg::WD_ID])
    else $error("masked source failed to show pending");

  pend_ro_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && idx == ilp_pkg::PEND_IDX && raw == pend_r |=> pend_r == $past(pend_r))
    else $error("pending flags changed by a write");

  ctl_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && ctl_hit && ctl_off == 8'h0B
    |=> ctl_rd[12] == ($past(i_pwdata[7:0]) & ilp_pkg::CTL_WMASK[12]))
    else $error("serial control register did not take the write");

  set_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && idx == ilp_pkg::CLR_IDX && ev != 16'h0000 |=> (stat_r & $past(ev)) == $past(ev))
    else $error("event lost in the cycle its status was cleared");

  // Every live request is covered by the level shown to the core
  for (genvar g = 1; g < ilp_pkg::NSRC; g++) begin : g_lvl_chk
    ipl_floor_a: assert property (@(posedge i_clk) disable iff (i_rst)
      arb_bus.req[g] |=> o_ipl >= $past(arb_bus.lvl[g]))
      else $error("core level below a live request");
  end

  // Reserved level bits hold each external at its own level
  for (genvar g = 1; g <= ilp_pkg::EXT_LAST; g++) begin : g_ext_chk
    ext_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
      arb_bus.lvl[g] == 3'(g))
      else $error("external source left its fixed level");
  end

  // Watchdog keeps level seven and never autovectors
  wd_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst)
    arb_bus.lvl[ilp_pkg::WD_ID] == 3'h7 && !ctl_rd[ilp_pkg::WD_ID][ilp_pkg::AUTOVEC_BIT])
    else $error("watchdog level or autovector bit not fixed");

  // Timer and i2c autovector bits can never be cleared
  for (genvar g = ilp_pkg::TMR1_ID; g <= ilp_pkg::I2C_ID; g++) begin : g_tmr_chk
    timer_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst)
      ctl_rd[g][ilp_pkg::AUTOVEC_BIT])
      else $error("timer or i2c autovector bit cleared");
  end

  // Bit zero has no source behind it
  unused_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !mask_r[0] && !pend_r[0] && !stat_r[0])
    else $error("bit zero of mask, pending or status came alive");

  // An acknowledge nobody can claim gets the level-zero autovector
  spurious_ack_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_iack_req && (!arb_bus.win_vld || arb_bus.top_lvl != i_iack_lvl)
    |=> o_iack_src == 4'h0 && o_iack_autovec && o_iack_vector == ilp_pkg::AUTOVEC_BASE)
    else $error("unmatched acknowledge not answered as spurious");

  // Pending tracks the request one cycle late whatever the mask says
  pend_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> pend_r == $past(raw))
    else $error("pending flags do not follow the requests");

  // Mask takes every writable bit of a write
  mask_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && idx == ilp_pkg::MASK_IDX
    |=> mask_r == ($past(i_pwdata[15:0]) & ilp_pkg::MASK_USED))
    else $error("mask register did not take the write");

endmodule // ilp_ctrl

// ==== dv/ilp_core_model.sv ====
// Behavioural core and peripheral requesters facing the interrupt controller.
module ilp_core_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_take,
  input wire logic [2:0] i_ipl,
  input wire logic [14:0] i_raise,
  output logic [6:0] o_ext_irq,
  output logic [7:0] o_per_irq,
  output logic o_iack_req,
  output logic [2:0] o_iack_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Requesters
  // ----------------------------------------------------------------
  // Levels held until the bench drops them, since pending follows them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ext_irq <= 7'h00;
      o_per_irq <= 8'h00;
    end else begin
      o_ext_irq <= i_raise[6:0];
      o_per_irq <= i_raise[14:7];
    end
  end
  // Core acknowledges the level it is shown; a non-autovector source answers itself
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_iack_req <= 1'b0;
      o_iack_lvl <= 3'h0;
    end else begin
      o_iack_req <= i_take;
      o_iack_lvl <= i_ipl;
    end
  end
endmodule // ilp_core_model

// ==== dv/ilp_ctrl_tb_top.sv ====
// Self-checking bench for the interrupt level, priority and mask controller.
module ilp_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, take;
  logic iack_req, iack_ack, autovec, irq;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rs;
  logic [6:0] ext;
  logic [7:0] per, vector;
  logic [2:0] iack_lvl, ipl, lvl;
  logic [1:0] pri;
  logic [3:0] src;
  logic [14:0] raise;
  logic [32:0] exp_q[$];
  string nm_q[$];
  int errors, comparisons;

  ilp_ctrl u_ilp_ctrl (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_irq(ext), .i_per_irq(per),
    .i_iack_req(iack_req), .i_iack_lvl(iack_lvl), .o_ipl(ipl), .o_iack_ack(iack_ack),
    .o_iack_autovec(autovec), .o_iack_vector(vector), .o_iack_src(src), .o_irq(irq));
  ilp_core_model u_ilp_core_model (.i_clk(clk), .i_rst(rst), .i_take(take), .i_ipl(ipl),
    .i_raise(raise), .o_ext_irq(ext), .o_per_irq(per), .o_iack_req(iack_req),
    .o_iack_lvl(iack_lvl));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] cidx(input int n);
    return ilp_pkg::CTL_IDX_BASE + 8'(n - 1);
  endfunction
  // Readback of a control register after writing d; d = 0 gives the reset value
  function automatic logic [7:0] exp_ctl(input int n, input logic [7:0] d);
    if (n <= 7) return {d[7], 2'b00, 3'(n), d[1:0]};
    if (n == 8) return {3'b000, 3'h7, d[1:0]};
    if (n <= 11) return {3'b100, d[4:0]};
    return {d[7], 2'b00, d[4:0]};
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer, then an idle cycle so no signal is set twice in a step
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    apb(1'b0, idx, 32'h0000_0000);
  endtask
  task automatic ack(input string nm, input logic [12:0] e);
    exp_q.push_back({20'h0_0000, e});
    nm_q.push_back(nm);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Levels are looked at mid-cycle, where the registered outputs have settled
  task automatic out_is(input string nm, input logic [2:0] e, input logic sel);
    @(negedge clk);
    chk(nm, {30'h0, e}, sel ? {32'h0, irq} : {30'h0, ipl});
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      chk(nm_q.pop_front(), exp_q.pop_front(), {pslverr, prdata});
    if (iack_ack === 1'b1)
      chk(nm_q.pop_front(), exp_q.pop_front(), {20'h0_0000, autovec, vector, src});
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    take = 1'b0;
    raise = 15'h0000;
    rs = 32'h0000_03EF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int n = 1; n <= 15; n++) rd("ctl reset", cidx(n), {25'h0, exp_ctl(n, 8'h00)});
    rd("mask reset", ilp_pkg::MASK_IDX, 33'h0_0000_3FFE);
    rd("pending reset", ilp_pkg::PEND_IDX, 33'h0);
    rd("wd vector reset", ilp_pkg::WDVEC_IDX, 33'h0_0000_000F);
    // Fixed and reserved fields survive all-ones and all-zeros writes
    for (int k = 0; k < 2; k++) begin
      for (int n = 1; n <= 15; n++) begin
        wr(cidx(n), k ? 32'h0 : 32'hFF);
        rd("ctl field", cidx(n), {25'h0, exp_ctl(n, k ? 8'h00 : 8'hFF)});
      end
    end
    // Unique level and priority pairs, controls before the mask
    rs = xs(rs);
    lvl = 3'(1 + rs % 4);
    pri = 2'(1 + (rs >> 8) % 3);
    wr(cidx(7), 32'h80);
    wr(cidx(8), 32'h03);
    wr(cidx(9), 32'h96);
    wr(cidx(12), 32'h17);
    wr(cidx(14), {24'h0, 3'b100, lvl, pri});
    wr(ilp_pkg::WDVEC_IDX, 32'h40);
    wr(ilp_pkg::EN_IDX, 32'h0200);
    wr(ilp_pkg::MASK_IDX, 32'h0);
    raise[8] <= 1'b1;
    repeat (3) @(posedge clk);
    out_is("ipl timer", 3'h5, 1'b0);
    ack("timer ack", {1'b1, 8'd29, 4'd9});
    raise[11] <= 1'b1;
    repeat (3) @(posedge clk);
    ack("serial ack", {1'b0, 8'd0, 4'd12});
    raise[7] <= 1'b1;
    repeat (3) @(posedge clk);
    out_is("ipl wd", 3'h7, 1'b0);
    ack("wd ack", {1'b0, 8'h40, 4'd8});
    wr(ilp_pkg::MASK_IDX, 32'h0100);
    out_is("ipl masked", 3'h5, 1'b0);
    rd("pending masked", ilp_pkg::PEND_IDX, 33'h0_0000_1300);
    wr(ilp_pkg::PEND_IDX, 32'h0);
    rd("pending write", ilp_pkg::PEND_IDX, 33'h0_0000_1300);
    raise[6] <= 1'b1;
    repeat (5) @(posedge clk);
    ack("ext7 ack", {1'b1, 8'd31, 4'd7});
    raise <= 15'h0000;
    repeat (6) @(posedge clk);
    out_is("ipl idle", 3'h0, 1'b0);
    ack("spurious ack", {1'b1, 8'd24, 4'd0});
    raise[13] <= 1'b1;
    repeat (3) @(posedge clk);
    out_is("ipl dma", lvl, 1'b0);
    ack("dma ack", {1'b1, 8'd24 + 8'(lvl), 4'd14});
    raise <= 15'h0000;
    // Sticky status, enable and clear
    out_is("irq set", 3'h1, 1'b1);
    rd("status", ilp_pkg::STAT_IDX, 33'h0_0000_5380);
    // Timer two fires on the very edge that clears its status bit: the set wins
    raise[9] <= 1'b1;
    wr(ilp_pkg::CLR_IDX, 32'h0600);
    out_is("irq clear", 3'h0, 1'b1);
    rd("status cleared", ilp_pkg::STAT_IDX, 33'h0_0000_5580);
    rd("clear reg", ilp_pkg::CLR_IDX, 33'h0);
    rd("unmapped", 8'h00, {1'b1, 32'h0});
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule // ilp_ctrl_tb_top
